// ### rtl/pio_map.svh
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH

// ------------------------------------------------------------
// register offsets (9-bit byte addresses)
// ------------------------------------------------------------
`define OFS_BOOT_LEVEL_LOW 9'h10A
`define OFS_BOOT_LEVEL_HIGH 9'h10B
`define OFS_BOOT_WAY_LOW 9'h10C
`define OFS_BOOT_WAY_HIGH 9'h10D
`define OFS_BOOT_FLIP_LOW 9'h10E
`define OFS_BOOT_FLIP_HIGH_AND_DRIVE 9'h10F
`define OFS_SERIAL_FIRST 9'h118
`define OFS_SERIAL_LAST 9'h11F
`define OFS_DRIVE_LEVEL_LOW 9'h120
`define OFS_DRIVE_LEVEL_HIGH 9'h121
`define OFS_LINE_WAY_LOW 9'h122
`define OFS_LINE_WAY_HIGH 9'h123
`define OFS_LINE_FLIP_LOW 9'h124
`define OFS_LINE_FLIP_HIGH_AND_DRIVE 9'h125
`define OFS_READBACK_LOW 9'h126
`define OFS_READBACK_HIGH 9'h127

// ------------------------------------------------------------
// factory values of the nonvolatile defaults
// ------------------------------------------------------------
`define RST_BOOT_LEVEL_LOW 8'hFF
`define RST_BOOT_LEVEL_HIGH 8'h0F
`define RST_BOOT_WAY_LOW 8'hFF
`define RST_BOOT_WAY_HIGH 8'h0F
`define RST_BOOT_FLIP_LOW 8'h00
`define RST_BOOT_FLIP_HIGH_AND_DRIVE 8'h80

// ------------------------------------------------------------
// field positions in the combined byte
// ------------------------------------------------------------
`define HIGH_NIBBLE_MASK 8'h0F
`define FLD_FLIP_HIGH_LSB 0
`define FLD_STYLE_LSB 4
`define FLD_STRENGTH 7
`define CRC_POLY_REFLECTED 8'h8C

`endif

// ### rtl/pio_pkg.sv
package pio_pkg;

  localparam int LINES = 12;

  typedef enum logic [1:0] {
    phase_boot,
    phase_run
  } phase_type;

  typedef struct packed {
    phase_type phase;
    logic [7:0] boot_level_low;
    logic [3:0] boot_level_high;
    logic [7:0] boot_way_low;
    logic [3:0] boot_way_high;
    logic [7:0] boot_flip_low;
    logic [7:0] boot_flip_high_and_drive;
    logic [11:0] drive_level;
    logic [11:0] line_way;
    logic [11:0] line_flip;
    logic [2:0] drive_style;
    logic drive_strength;
    logic [11:0] applied_level;
    logic [3:0] seq_index;
    logic [7:0] rdata;
    logic rvalid;
  } state_type;

endpackage

// ### rtl/crc8_check.sv
`timescale 1ns/10ps
`include "pio_map.svh"

// check byte over the first seven registration bytes, lsb first
module crc8_check (
  input wire logic [55:0] data,
  output logic [7:0] crc
);

  // ------------------------------------------------------------
  // bit-serial crc, x^8+x^5+x^4+1 in reflected form
  // ------------------------------------------------------------
  always_comb begin
    logic mix;
    mix = 1'b0;
    crc = 8'h00;
    for (int i = 0; i < 56; i++) begin
      mix = crc[0] ^ data[i];
      crc = {1'b0, crc[7:1]};
      if (mix) begin
        crc = crc ^ `CRC_POLY_REFLECTED;
      end
    end
  end

endmodule // crc8_check

// ### rtl/port_line_cell.sv
`timescale 1ns/10ps

// one port line: driver style and read-back inversion
module port_line_cell (
  input wire logic way,
  input wire logic level,
  input wire logic open_drain,
  input wire logic flip,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic read_value
);

  // ------------------------------------------------------------
  // driver: input way tri-states, open drain only pulls low
  // ------------------------------------------------------------
  always_comb begin
    if (way) begin
      pin_out = 1'b0;
      pin_oe = 1'b0;
    end else if (open_drain) begin
      pin_out = 1'b0;
      pin_oe = ~level;
    end else begin
      pin_out = level;
      pin_oe = 1'b1;
    end
  end

  // pin level seen through the inversion bit, any direction
  assign read_value = pin_in ^ flip;

endmodule // port_line_cell

// ### rtl/pio_config_and_boot_defaults.sv
//
// Function
// - power-up copies default direction bytes into live direction registers
// - default direction ships as all inputs: FFh low, 0Fh high
// - direction bit n steers line n; zero output, one input
// - default read inversion low ships 00h, copied to live at power-up
// - combined default byte ships 80h, copied to live combined byte
// - inversion bit per line; combined byte bits 0-3 serve lines 8-11
// - bits 4,5,6 pick push-pull or open drain per group of four
// - bit 7 picks low-current simultaneous or high-current sequential switching
// - registration number: family code, 48-bit serial lsb first, crc byte
// - check byte is crc with polynomial x^8+x^5+x^4+1
// - power-up loads live output states from default output states
// - output state bit drives line low or high only when output
// - default and live registers read/write; upper nibble of high bytes reserved
// - live writes change lines without touching stored defaults
// - input lines have their driver tri-stated
// - read-back is pin level xor inversion bit regardless of direction
//
`timescale 1ns/10ps
`include "pio_map.svh"

module pio_config_and_boot_defaults #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0123456789AB // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic refresh,
  input wire logic [8:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic busy,
  input wire logic [11:0] port_line_in,
  output logic [11:0] port_line_out,
  output logic [11:0] port_line_oe,
  output logic [11:0] port_line_read,
  output logic [2:0] drive_style,
  output logic high_current
);

  // ------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------
  pio_pkg::state_type state;
  pio_pkg::state_type next_state;
  logic [7:0] crc_byte;
  logic [63:0] registration;
  logic [11:0] line_read;
  logic [11:0] group_style;

  // reserved upper nibble is dropped on the way in
  function automatic logic [3:0] low_nibble(input logic [7:0] value);
    low_nibble = value[3:0];
  endfunction

  // widen a 4-bit field to a byte with zero upper bits
  function automatic logic [7:0] pad_nibble(input logic [3:0] value);
    pad_nibble = {4'h0, value};
  endfunction

  // ------------------------------------------------------------
  // registration number with its check byte
  // ------------------------------------------------------------
  crc8_check u_crc (
    .data({SERIAL_NUMBER, FAMILY_CODE}),
    .crc(crc_byte)
  );

  // family code lowest, serial lsb first, crc at the top
  assign registration = {crc_byte, SERIAL_NUMBER, FAMILY_CODE};

  // ------------------------------------------------------------
  // port line cells
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < pio_pkg::LINES; g++) begin : g_line
      // one style bit per group of four lines
      assign group_style[g] = state.drive_style[g / 4];
      port_line_cell u_cell (
        .way(state.line_way[g]),
        .level(state.applied_level[g]),
        .open_drain(group_style[g]),
        .flip(state.line_flip[g]),
        .pin_in(port_line_in[g]),
        .pin_out(port_line_out[g]),
        .pin_oe(port_line_oe[g]),
        .read_value(line_read[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.rvalid = 1'b0;

    unique case (state.phase)
      // copy all defaults to live in one step; nv side untouched
      pio_pkg::phase_boot: begin
        next_state.drive_level = {state.boot_level_high, state.boot_level_low};
        next_state.line_way = {state.boot_way_high, state.boot_way_low};
        next_state.line_flip = {low_nibble(state.boot_flip_high_and_drive), state.boot_flip_low};
        next_state.drive_style = state.boot_flip_high_and_drive[`FLD_STYLE_LSB +: 3];
        next_state.drive_strength = state.boot_flip_high_and_drive[`FLD_STRENGTH];
        next_state.applied_level = {state.boot_level_high, state.boot_level_low};
        next_state.seq_index = 4'h0;
        next_state.phase = pio_pkg::phase_run;
      end

      pio_pkg::phase_run: begin
        // register writes; serial number and read-back ignore writes
        if (reg_wr) begin
          unique case (reg_addr)
            `OFS_BOOT_LEVEL_LOW: next_state.boot_level_low = reg_wdata;
            `OFS_BOOT_LEVEL_HIGH: next_state.boot_level_high = low_nibble(reg_wdata);
            `OFS_BOOT_WAY_LOW: next_state.boot_way_low = reg_wdata;
            `OFS_BOOT_WAY_HIGH: next_state.boot_way_high = low_nibble(reg_wdata);
            `OFS_BOOT_FLIP_LOW: next_state.boot_flip_low = reg_wdata;
            `OFS_BOOT_FLIP_HIGH_AND_DRIVE: next_state.boot_flip_high_and_drive = reg_wdata;
            `OFS_DRIVE_LEVEL_LOW: next_state.drive_level[7:0] = reg_wdata;
            `OFS_DRIVE_LEVEL_HIGH: next_state.drive_level[11:8] = low_nibble(reg_wdata);
            `OFS_LINE_WAY_LOW: next_state.line_way[7:0] = reg_wdata;
            `OFS_LINE_WAY_HIGH: next_state.line_way[11:8] = low_nibble(reg_wdata);
            `OFS_LINE_FLIP_LOW: next_state.line_flip[7:0] = reg_wdata;
            `OFS_LINE_FLIP_HIGH_AND_DRIVE: begin
              next_state.line_flip[11:8] = low_nibble(reg_wdata);
              next_state.drive_style = reg_wdata[`FLD_STYLE_LSB +: 3];
              next_state.drive_strength = reg_wdata[`FLD_STRENGTH];
            end
            default: begin
            end
          endcase
        end

        // output switching: all at once, or one line per clock in index order
        if (!state.drive_strength) begin
          next_state.applied_level = state.drive_level;
          next_state.seq_index = 4'h0;
        end else begin
          next_state.applied_level[state.seq_index] = state.drive_level[state.seq_index];
          if (state.seq_index == 4'(pio_pkg::LINES - 1)) begin
            next_state.seq_index = 4'h0;
          end else begin
            next_state.seq_index = state.seq_index + 4'h1;
          end
        end

        // refresh reruns the power-up copy on the next clock
        if (refresh) begin
          next_state.phase = pio_pkg::phase_boot;
        end
      end

      default: begin
        next_state.phase = pio_pkg::phase_boot;
      end
    endcase

    // read port: data one clock after the strobe, unmapped reads zero
    if (reg_rd && state.phase == pio_pkg::phase_run) begin
      next_state.rvalid = 1'b1;
      if (reg_addr >= `OFS_SERIAL_FIRST && reg_addr <= `OFS_SERIAL_LAST) begin
        next_state.rdata = registration[8 * (reg_addr - `OFS_SERIAL_FIRST) +: 8];
      end else begin
        unique case (reg_addr)
          `OFS_BOOT_LEVEL_LOW: next_state.rdata = state.boot_level_low;
          `OFS_BOOT_LEVEL_HIGH: next_state.rdata = pad_nibble(state.boot_level_high);
          `OFS_BOOT_WAY_LOW: next_state.rdata = state.boot_way_low;
          `OFS_BOOT_WAY_HIGH: next_state.rdata = pad_nibble(state.boot_way_high);
          `OFS_BOOT_FLIP_LOW: next_state.rdata = state.boot_flip_low;
          `OFS_BOOT_FLIP_HIGH_AND_DRIVE: next_state.rdata = state.boot_flip_high_and_drive;
          `OFS_DRIVE_LEVEL_LOW: next_state.rdata = state.drive_level[7:0];
          `OFS_DRIVE_LEVEL_HIGH: next_state.rdata = pad_nibble(state.drive_level[11:8]);
          `OFS_LINE_WAY_LOW: next_state.rdata = state.line_way[7:0];
          `OFS_LINE_WAY_HIGH: next_state.rdata = pad_nibble(state.line_way[11:8]);
          `OFS_LINE_FLIP_LOW: next_state.rdata = state.line_flip[7:0];
          `OFS_LINE_FLIP_HIGH_AND_DRIVE: begin
            next_state.rdata = {state.drive_strength, state.drive_style, state.line_flip[11:8]};
          end
          `OFS_READBACK_LOW: next_state.rdata = line_read[7:0];
          `OFS_READBACK_HIGH: next_state.rdata = pad_nibble(line_read[11:8]);
          default: next_state.rdata = 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // state register; reset stands for first power-up
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state.phase <= pio_pkg::phase_boot;
      state.boot_level_low <= `RST_BOOT_LEVEL_LOW;
      state.boot_level_high <= 4'(`RST_BOOT_LEVEL_HIGH);
      state.boot_way_low <= `RST_BOOT_WAY_LOW;
      state.boot_way_high <= 4'(`RST_BOOT_WAY_HIGH);
      state.boot_flip_low <= `RST_BOOT_FLIP_LOW;
      state.boot_flip_high_and_drive <= `RST_BOOT_FLIP_HIGH_AND_DRIVE;
      // live side parks as inputs until the boot copy lands
      state.drive_level <= 12'h000;
      state.line_way <= 12'hFFF;
      state.line_flip <= 12'h000;
      state.drive_style <= 3'h0;
      state.drive_strength <= 1'b0;
      state.applied_level <= 12'h000;
      state.seq_index <= 4'h0;
      state.rdata <= 8'h00;
      state.rvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign busy = (state.phase != pio_pkg::phase_run);
  assign port_line_read = line_read;
  assign drive_style = state.drive_style;
  assign high_current = state.drive_strength;

endmodule // pio_config_and_boot_defaults

// ### bench/pio_config_chk.sv
`timescale 1ns/10ps
`include "pio_map.svh"
// ------------------------
// port checks
// ------------------------
module pio_config_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic refresh,
  input wire logic [8:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic busy,
  input wire logic [11:0] port_line_in,
  input wire logic [11:0] port_line_out,
  input wire logic [11:0] port_line_oe,
  input wire logic [11:0] port_line_read,
  input wire logic [2:0] drive_style,
  input wire logic high_current
);
  // one clock domain, so one clocking and one reset for all checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // group style spread out to one bit per line
  logic [11:0] od_mask;
  assign od_mask = {{4{drive_style[2]}}, {4{drive_style[1]}}, {4{drive_style[0]}}};

  // boot copy, register port and line checks
  a_boot_copy_busy: assert property ($fell(rst) |-> busy ##1 !busy)
    else $error("busy not one cycle after reset");
  a_boot_all_in: assert property ($fell(rst) |=>
    port_line_oe == 12'h000 && high_current && drive_style == 3'h0) else $error("boot state wrong");
  a_read_answer: assert property (reg_rd && !busy |=> reg_rvalid)
    else $error("read got no answer");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd) && !$past(busy))
    else $error("answer without read");
  a_flip_steady: assert property (!$past(reg_wr) && !$past(busy) && !$past(refresh) |->
    $stable(port_line_read ^ port_line_in)) else $error("read inversion moved");
  a_open_drain_low: assert property ((port_line_out & od_mask) == 12'h000)
    else $error("open-drain line driven high");
  a_refresh_busy: assert property (refresh && !busy |=> busy ##1 !busy)
    else $error("refresh copy cycle wrong");
  a_mode_write: assert property (reg_wr && !busy && reg_addr == `OFS_LINE_FLIP_HIGH_AND_DRIVE |=>
    {high_current, drive_style} == 4'($past(reg_wdata) >> 4)) else $error("mode byte not applied");
  c_refresh: cover property (refresh && !busy);
  c_open_drain: cover property (|(port_line_oe & od_mask));
  c_high_drive: cover property (high_current && |port_line_oe);
endmodule // pio_config_chk

bind pio_config_and_boot_defaults pio_config_chk i_chk (.sys_clk, .rst, .refresh, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rd, .reg_rdata, .reg_rvalid, .busy, .port_line_in, .port_line_out, .port_line_oe, .port_line_read,
  .drive_style, .high_current);

// ### bench/pin_model.sv
`timescale 1ns/10ps
// ------------------------
// external pin circuitry
// ------------------------
module pin_model (
  input wire logic [11:0] port_line_out,
  input wire logic [11:0] port_line_oe,
  input wire logic [11:0] pull_level,
  output logic [11:0] port_line_in
);
  // a released line falls to its pull resistor, never keeps the old value
  assign port_line_in = (port_line_oe & port_line_out) | (~port_line_oe & pull_level);
endmodule // pin_model

// ### bench/tb.sv
`timescale 1ns/10ps
// ------------------------
// self-checking bench
// ------------------------
module tb;
  localparam logic [7:0] FAM = 8'h3C; // arbitrary value
  localparam logic [47:0] SER = 48'h00A1B2C3D4E5; // arbitrary value
  logic sys_clk, rst, refresh, reg_wr, reg_rd, reg_rvalid, busy, high_current;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [11:0] port_line_in, port_line_out, port_line_oe, port_line_read, pull_level;
  logic [2:0] drive_style;
  int errors, n_tests;

  pio_config_and_boot_defaults #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER)) i_dut (.sys_clk, .rst, .refresh,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .busy, .port_line_in, .port_line_out,
    .port_line_oe, .port_line_read, .drive_style, .high_current);
  pin_model i_pins (.port_line_out, .port_line_oe, .pull_level, .port_line_in);

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // strobes held one cycle, so back-to-back calls leave a gap cycle
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("rvalid", {11'h000, reg_rvalid}, 12'h001);
    check("rdata", {4'h0, reg_rdata}, {4'h0, exp});
  endtask

  // own crc, reflected form of x^8+x^5+x^4+1, lsb first
  function automatic logic [7:0] crc_of(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction

  task automatic t_power_up();
    rd(9'h10C, 8'hFF);
    rd(9'h10D, 8'h0F);
    rd(9'h10E, 8'h00);
    rd(9'h10F, 8'h80);
    rd(9'h120, 8'hFF);
    rd(9'h121, 8'h0F);
    rd(9'h122, 8'hFF);
    rd(9'h123, 8'h0F);
    rd(9'h124, 8'h00);
    rd(9'h125, 8'h80);
    check("oe", port_line_oe, 12'h000);
  endtask

  task automatic t_serial();
    logic [63:0] id;
    id = {crc_of({SER, FAM}), SER, FAM};
    for (int i = 0; i < 8; i++) rd(9'h118 + 9'(i), id[8*i+:8]);
    wr(9'h118, 8'h00);
    rd(9'h118, FAM);
    rd(9'h100, 8'h00);
  endtask

  task automatic t_drive();
    wr(9'h125, 8'h00);
    wr(9'h120, 8'hA5);
    wr(9'h121, 8'h03);
    wr(9'h122, 8'h00);
    wr(9'h123, 8'h00);
    settle(2);
    check("oe", port_line_oe, 12'hFFF);
    check("out", port_line_out, 12'h3A5);
    rd(9'h126, 8'hA5);
    wr(9'h124, 8'hFF);
    wr(9'h125, 8'h0F);
    settle(2);
    check("read", port_line_read, 12'hC5A);
    rd(9'h127, 8'h0C);
  endtask

  // lines 0-3 become inputs and fall to the pull-ups
  task automatic t_direction();
    wr(9'h122, 8'h0F);
    settle(2);
    check("oe", port_line_oe, 12'hFF0);
    check("read", port_line_read, 12'hC50);
  endtask

  task automatic t_mode();
    wr(9'h125, 8'h70);
    settle(2);
    check("out", port_line_out, 12'h000);
    check("oe", port_line_oe, 12'hC50);
    check("mode", {8'h00, high_current, drive_style}, 12'h007);
    wr(9'h125, 8'h80);
    wr(9'h120, 8'h5A);
    settle(14);
    // lines 0-3 are still inputs, so their drive value stays low
    check("out", port_line_out, 12'h350);
    check("mode", {8'h00, high_current, drive_style}, 12'h008);
  endtask

  task automatic t_refresh();
    wr(9'h123, 8'hFF);
    rd(9'h123, 8'h0F);
    wr(9'h10D, 8'hF0);
    rd(9'h10D, 8'h00);
    rd(9'h10C, 8'hFF);
    wr(9'h10C, 8'h55);
    @(posedge sys_clk);
    refresh <= 1'b1;
    @(posedge sys_clk);
    refresh <= 1'b0;
    #1;
    check("busy", {11'h000, busy}, 12'h001);
    settle(2);
    check("busy", {11'h000, busy}, 12'h000);
    rd(9'h122, 8'h55);
    rd(9'h123, 8'h00);
    rd(9'h125, 8'h80);
    check("oe", port_line_oe, 12'hFAA);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    refresh = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    pull_level = 12'hFFF;
    errors = 0;
    n_tests = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    settle(2);
    t_power_up();
    t_serial();
    t_drive();
    t_direction();
    t_mode();
    t_refresh();
    summarize();
  end

  // watchdog: the run needs well under 1000 cycles
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule // tb
